// ### hdl/dsp_multiply_accumulate.sv
// Multiply-accumulate datapath with Wishbone register access
// Operation
// - 17x17 signed/unsigned multiplier; scaler gives 1.31 or integer result.
// - 16-bit operands widened to 17 bits by zero or sign fill.
// - Multiplier output is 34 bits; the 33-bit scaled result is sign-extended to 40 bits.
// - Fraction mode treats operands as Q15 and yields a 1.31 product.
// - Same multiplier performs signed, unsigned and mixed integer multiplies.
// - Integer product gives 16-bit result for bytes, 32-bit for words.
// - 40-bit adder/subtracter; one accumulator is source and destination.
// - Add and load data may pass through the barrel shifter first.
// - One adder input may be zero, the other true or complemented.
// - Add uses true data, carry high; subtract complements, borrow low.
// - Adder produces clip and guard overflow flags latched in status.
// - Carry out of bit 39 is catastrophic overflow, sign lost.
// - Guard overflow flagged when bits 39..32 are not all equal.
// - Clip decision uses result, overflows, enables bits 7:6, mode bit 4.
// - Per-accumulator guard flags report each accumulator's overflow.
// - Clip flag set on bit 31 overflow or bit 39 overflow clipping.
// - Combined guard overflow flag is the OR of both.
// - Status word is 16 bits, bits 15:10 adder flags, bits 9:0 core.
// - Combined clip flag is the OR of both clip flags.
// - Guard flags update each adder pass; flag with trap enable raises trap.
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dsp_multiply_accumulate (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mac_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [mac_pkg::DAT_W-1:0] wb_dat_i,
  output logic [mac_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Core side
  output logic arith_trap_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic ack_r;
  logic [mac_pkg::DAT_W-1:0] rdata_r;
  logic [mac_pkg::WORD_W-1:0] core_control_word;
  logic [mac_pkg::WORD_W-1:0] oper_a_r;
  logic [mac_pkg::WORD_W-1:0] oper_b_r;
  logic [mac_pkg::DAT_W-1:0] last_cmd_r;
  logic [mac_pkg::ACC_W-1:0] accum_first;
  logic [mac_pkg::ACC_W-1:0] accum_second;
  logic [mac_pkg::DAT_W-1:0] product_r;
  logic acc_first_guard_ovf;
  logic acc_second_guard_ovf;
  logic acc_first_clip_flag;
  logic acc_second_clip_flag;
  logic either_guard_ovf;
  logic either_clip_flag;
  logic loop_active_flag;
  logic digit_carry_flag;
  logic [mac_pkg::ST_LOW_W-1:0] status_low_byte;
  logic first_ovf_trap_en;
  logic second_ovf_trap_en;
  logic trap_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr_stb;
  logic [mac_pkg::DAT_W-1:0] wmask;

  // A request is taken once; ack drops the cycle after it rose
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_stb = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [mac_pkg::DAT_W-1:0] merge(
    input logic [mac_pkg::DAT_W-1:0] old_v,
    input logic [mac_pkg::DAT_W-1:0] new_v,
    input logic [mac_pkg::DAT_W-1:0] mask
  );
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  // ----------------------------------------------------------------
  // Command and operand preparation
  // ----------------------------------------------------------------
  mac_pkg::cmd_type cmd;
  logic exec;
  logic is_sub;
  logic zero_in;
  logic use_shift;
  logic [mac_pkg::WORD_W-1:0] op_a16;
  logic [mac_pkg::WORD_W-1:0] op_b16;
  logic signed [mac_pkg::MUL_IN_W-1:0] mul_a;
  logic signed [mac_pkg::MUL_IN_W-1:0] mul_b;
  logic signed [mac_pkg::PROD_W-1:0] prod;
  logic [mac_pkg::SCALED_W-1:0] scaled;
  logic [mac_pkg::ACC_W-1:0] prod40;
  logic [mac_pkg::ACC_W-1:0] data40;
  logic [mac_pkg::ACC_W-1:0] shifted40;
  logic [5:0] shift_left_amt;

  // Only full-word command writes execute, so a partial lane write
  // cannot launch a half-formed operation
  assign cmd = mac_pkg::cmd_type'(wb_dat_i);
  assign exec = wr_stb && (wb_adr_i == mac_pkg::OFS_CMD) && (&wb_sel_i);

  always_comb begin
    is_sub = 1'b0;
    zero_in = 1'b0;
    use_shift = 1'b0;
    unique case (mac_pkg::op_type'(cmd.op))
      mac_pkg::OP_MSC: is_sub = 1'b1;
      mac_pkg::OP_MPY: zero_in = 1'b1;
      mac_pkg::OP_ADD: use_shift = 1'b1;
      mac_pkg::OP_SUB: begin
        use_shift = 1'b1;
        is_sub = 1'b1;
      end
      mac_pkg::OP_LOAD: begin
        use_shift = 1'b1;
        zero_in = 1'b1;
      end
      default: begin
        is_sub = 1'b0;
      end
    endcase
  end

  // Byte operands are first brought to 16 bits in the same signedness
  always_comb begin
    op_a16 = oper_a_r;
    op_b16 = oper_b_r;
    if (cmd.byte_mode) begin
      op_a16 = {{8{cmd.a_signed & oper_a_r[7]}}, oper_a_r[7:0]};
      op_b16 = {{8{cmd.b_signed & oper_b_r[7]}}, oper_b_r[7:0]};
    end
  end

  // 17th bit is sign or zero depending on each operand's form
  assign mul_a = {cmd.a_signed & op_a16[15], op_a16};
  assign mul_b = {cmd.b_signed & op_b16[15], op_b16};
  // Mixed and like-signed integer products share this one multiplier
  assign prod = mul_a * mul_b;

  // Fraction mode drops the duplicated sign bit to give 1.31
  always_comb begin
    if (core_control_word[mac_pkg::CTL_FRAC]) begin
      scaled = {prod[31:0], 1'b0};
    end else begin
      scaled = prod[32:0];
    end
  end

  assign prod40 = {{7{scaled[32]}}, scaled};

  // Word data lands in bits 31:16, then the barrel shifter scales it;
  // positive counts shift right, negative counts shift left
  assign data40 = {{8{oper_a_r[15]}}, oper_a_r, 16'h0000};
  // Six bits so that a count of -16 still shifts by sixteen places
  assign shift_left_amt = 6'(-cmd.shift);
  always_comb begin
    if (cmd.shift[4]) begin
      shifted40 = data40 << shift_left_amt;
    end else begin
      shifted40 = 40'($signed(data40) >>> cmd.shift);
    end
  end

  // ----------------------------------------------------------------
  // Adder, overflow detection and saturation
  // ----------------------------------------------------------------
  logic [mac_pkg::ACC_W-1:0] acc_src;
  logic [mac_pkg::ACC_W-1:0] in_x;
  logic [mac_pkg::ACC_W-1:0] in_data;
  logic [mac_pkg::ACC_W-1:0] in_y;
  logic cin;
  logic [mac_pkg::SUM_W-1:0] sum;
  logic cat_ovf;
  logic guard_ovf;
  logic narrow_ovf;
  logic clip_en;
  logic clip_hit;
  logic [mac_pkg::ACC_W-1:0] result;

  assign acc_src = cmd.acc_second ? accum_second : accum_first;
  assign in_x = zero_in ? '0 : acc_src;
  assign in_data = use_shift ? shifted40 : prod40;
  assign in_y = is_sub ? ~in_data : in_data;
  // Borrow input is active low when subtracting
  assign cin = is_sub ? ~cmd.carry : cmd.carry;
  // One extra bit keeps the true sign past a bit 39 carry
  assign sum = {in_x[39], in_x} + {in_y[39], in_y} + 41'(cin);
  assign cat_ovf = sum[40] ^ sum[39];
  assign guard_ovf = !((&sum[39:32]) || !(|sum[39:32]));
  assign narrow_ovf = !((&sum[40:31]) || !(|sum[40:31]));

  assign clip_en = cmd.acc_second ?
                   core_control_word[mac_pkg::CTL_CLIP_SECOND] :
                   core_control_word[mac_pkg::CTL_CLIP_FIRST];

  always_comb begin
    result = sum[39:0];
    clip_hit = 1'b0;
    if (clip_en) begin
      if (core_control_word[mac_pkg::CTL_WIDE_CLIP]) begin
        if (cat_ovf) begin
          clip_hit = 1'b1;
          result = sum[40] ? mac_pkg::WIDE_MIN : mac_pkg::WIDE_MAX;
        end
      end else if (narrow_ovf) begin
        clip_hit = 1'b1;
        result = sum[40] ? mac_pkg::NARROW_MIN : mac_pkg::NARROW_MAX;
      end
    end
  end

  logic acc_pass;
  logic hit_first;
  logic hit_second;

  assign acc_pass = exec && (cmd.op != mac_pkg::OP_NOP) &&
                    (cmd.op != mac_pkg::OP_PRODUCT) &&
                    (cmd.op <= mac_pkg::OP_LOAD);
  assign hit_first = acc_pass && !cmd.acc_second;
  assign hit_second = acc_pass && cmd.acc_second;

  // ----------------------------------------------------------------
  // Accumulators and integer product
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accum_first <= '0;
      accum_second <= '0;
    end else begin
      if (hit_first) begin
        accum_first <= result;
      end
      if (hit_second) begin
        accum_second <= result;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      product_r <= '0;
    end else if (exec && cmd.op == mac_pkg::OP_PRODUCT) begin
      if (cmd.byte_mode) begin
        product_r <= {16'h0000, prod[15:0]};
      end else begin
        product_r <= prod[31:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic st_wr;
  logic [mac_pkg::DAT_W-1:0] st_new;
  logic clip1_nxt;
  logic clip2_nxt;
  logic ovf1_nxt;
  logic ovf2_nxt;
  logic [mac_pkg::WORD_W-1:0] status_word;

  assign st_wr = wr_stb && (wb_adr_i == mac_pkg::OFS_STATUS);
  assign st_new = merge(32'(status_word), wb_dat_i, wmask);

  // Guard flags track the latest pass for the accumulator it wrote
  assign ovf1_nxt = hit_first ? guard_ovf : acc_first_guard_ovf;
  assign ovf2_nxt = hit_second ? guard_ovf : acc_second_guard_ovf;

  // Clip flags are sticky; software clears with a zero, but a clip
  // in the same cycle keeps the flag set
  always_comb begin
    clip1_nxt = acc_first_clip_flag;
    clip2_nxt = acc_second_clip_flag;
    if (st_wr) begin
      clip1_nxt = st_new[mac_pkg::ST_CLIP_FIRST];
      clip2_nxt = st_new[mac_pkg::ST_CLIP_SECOND];
    end
    if (hit_first && clip_hit) begin
      clip1_nxt = 1'b1;
    end
    if (hit_second && clip_hit) begin
      clip2_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_first_guard_ovf <= 1'b0;
      acc_second_guard_ovf <= 1'b0;
      acc_first_clip_flag <= 1'b0;
      acc_second_clip_flag <= 1'b0;
      either_guard_ovf <= 1'b0;
      either_clip_flag <= 1'b0;
    end else begin
      acc_first_guard_ovf <= ovf1_nxt;
      acc_second_guard_ovf <= ovf2_nxt;
      acc_first_clip_flag <= clip1_nxt;
      acc_second_clip_flag <= clip2_nxt;
      // Built from the next values so they never lag their sources
      either_guard_ovf <= ovf1_nxt | ovf2_nxt;
      either_clip_flag <= clip1_nxt | clip2_nxt;
    end
  end

  // Core-owned bits are kept here for the sequencer and software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_active_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      status_low_byte <= mac_pkg::ST_LOW_RESET;
    end else if (st_wr) begin
      loop_active_flag <= st_new[mac_pkg::ST_LOOP_ACT];
      digit_carry_flag <= st_new[mac_pkg::ST_DIGIT_CARRY];
      status_low_byte <= st_new[mac_pkg::ST_LOW_LSB +: mac_pkg::ST_LOW_W];
    end
  end

  // A plain signal, so every reader re-evaluates when any flag moves
  always_comb begin
    status_word = '0;
    status_word[mac_pkg::ST_OVF_FIRST] = acc_first_guard_ovf;
    status_word[mac_pkg::ST_OVF_SECOND] = acc_second_guard_ovf;
    status_word[mac_pkg::ST_CLIP_FIRST] = acc_first_clip_flag;
    status_word[mac_pkg::ST_CLIP_SECOND] = acc_second_clip_flag;
    status_word[mac_pkg::ST_OVF_EITHER] = either_guard_ovf;
    status_word[mac_pkg::ST_CLIP_EITHER] = either_clip_flag;
    status_word[mac_pkg::ST_LOOP_ACT] = loop_active_flag;
    status_word[mac_pkg::ST_DIGIT_CARRY] = digit_carry_flag;
    status_word[mac_pkg::ST_LOW_LSB +: mac_pkg::ST_LOW_W] = status_low_byte;
  end

  // ----------------------------------------------------------------
  // Control, operand and trap enable registers
  // ----------------------------------------------------------------
  logic [mac_pkg::DAT_W-1:0] ctl_new;
  logic [mac_pkg::DAT_W-1:0] opa_new;
  logic [mac_pkg::DAT_W-1:0] opb_new;

  assign ctl_new = merge(32'(core_control_word), wb_dat_i, wmask);
  assign opa_new = merge(32'(oper_a_r), wb_dat_i, wmask);
  assign opb_new = merge(32'(oper_b_r), wb_dat_i, wmask);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_control_word <= mac_pkg::CTL_RESET;
    end else if (wr_stb && wb_adr_i == mac_pkg::OFS_CTRL) begin
      core_control_word <= ctl_new[15:0] & mac_pkg::CTL_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oper_a_r <= '0;
      oper_b_r <= '0;
    end else begin
      if (wr_stb && wb_adr_i == mac_pkg::OFS_OPER_A) begin
        oper_a_r <= opa_new[15:0];
      end
      if (wr_stb && wb_adr_i == mac_pkg::OFS_OPER_B) begin
        oper_b_r <= opb_new[15:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_cmd_r <= '0;
    end else if (exec) begin
      last_cmd_r <= wb_dat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_ovf_trap_en <= 1'b0;
      second_ovf_trap_en <= 1'b0;
    end else if (wr_stb && wb_adr_i == mac_pkg::OFS_TRAP_EN &&
                 wb_sel_i[0]) begin
      first_ovf_trap_en <= wb_dat_i[mac_pkg::TE_FIRST];
      second_ovf_trap_en <= wb_dat_i[mac_pkg::TE_SECOND];
    end
  end

  // Trap is a level that follows the flags one cycle behind
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_r <= 1'b0;
    end else begin
      trap_r <= (acc_first_guard_ovf & first_ovf_trap_en) |
                (acc_second_guard_ovf & second_ovf_trap_en);
    end
  end

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  logic [mac_pkg::DAT_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      mac_pkg::OFS_CTRL: rd_mux = 32'(core_control_word);
      mac_pkg::OFS_OPER_A: rd_mux = 32'(oper_a_r);
      mac_pkg::OFS_OPER_B: rd_mux = 32'(oper_b_r);
      mac_pkg::OFS_CMD: rd_mux = last_cmd_r;
      mac_pkg::OFS_STATUS: rd_mux = 32'(status_word);
      mac_pkg::OFS_ACC1_LO: rd_mux = accum_first[31:0];
      mac_pkg::OFS_ACC1_HI: rd_mux = {24'h000000, accum_first[39:32]};
      mac_pkg::OFS_ACC2_LO: rd_mux = accum_second[31:0];
      mac_pkg::OFS_ACC2_HI: rd_mux = {24'h000000, accum_second[39:32]};
      mac_pkg::OFS_PROD: rd_mux = product_r;
      mac_pkg::OFS_TRAP_EN: rd_mux = {30'h0, second_ovf_trap_en,
                                      first_ovf_trap_en};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= req;
      if (req && !wb_we_i) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign arith_trap_o = trap_r;

endmodule : dsp_multiply_accumulate

`default_nettype wire

// ### hdl/mac_pkg.sv
// Constants, register map and command layout for the multiply-accumulate unit
package mac_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned MUL_IN_W = 17;
  localparam int unsigned PROD_W = 34;
  localparam int unsigned SCALED_W = 33;
  localparam int unsigned ACC_W = 40;
  localparam int unsigned SUM_W = 41;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_OPER_A = 8'h04;
  localparam logic [ADR_W-1:0] OFS_OPER_B = 8'h08;
  localparam logic [ADR_W-1:0] OFS_CMD = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADR_W-1:0] OFS_ACC1_LO = 8'h14;
  localparam logic [ADR_W-1:0] OFS_ACC1_HI = 8'h18;
  localparam logic [ADR_W-1:0] OFS_ACC2_LO = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_ACC2_HI = 8'h20;
  localparam logic [ADR_W-1:0] OFS_PROD = 8'h24;
  localparam logic [ADR_W-1:0] OFS_TRAP_EN = 8'h28;

  // ----------------------------------------------------------------
  // Core control word fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_FRAC = 0;
  localparam int unsigned CTL_WIDE_CLIP = 4;
  localparam int unsigned CTL_CLIP_SECOND = 6;
  localparam int unsigned CTL_CLIP_FIRST = 7;
  localparam logic [WORD_W-1:0] CTL_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] CTL_MASK = 16'h00D1;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_OVF_FIRST = 15;
  localparam int unsigned ST_OVF_SECOND = 14;
  localparam int unsigned ST_CLIP_FIRST = 13;
  localparam int unsigned ST_CLIP_SECOND = 12;
  localparam int unsigned ST_OVF_EITHER = 11;
  localparam int unsigned ST_CLIP_EITHER = 10;
  localparam int unsigned ST_LOOP_ACT = 9;
  localparam int unsigned ST_DIGIT_CARRY = 8;
  localparam int unsigned ST_LOW_LSB = 0;
  localparam int unsigned ST_LOW_W = 8;
  localparam logic [ST_LOW_W-1:0] ST_LOW_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Trap enable fields
  // ----------------------------------------------------------------
  localparam int unsigned TE_FIRST = 0;
  localparam int unsigned TE_SECOND = 1;

  // ----------------------------------------------------------------
  // Saturation limits
  // ----------------------------------------------------------------
  localparam logic [ACC_W-1:0] NARROW_MAX = 40'h007FFFFFFF;
  localparam logic [ACC_W-1:0] NARROW_MIN = 40'hFF80000000;
  localparam logic [ACC_W-1:0] WIDE_MAX = 40'h7FFFFFFFFF;
  localparam logic [ACC_W-1:0] WIDE_MIN = 40'h8000000000;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_MAC = 4'h1,
    OP_MSC = 4'h2,
    OP_MPY = 4'h3,
    OP_ADD = 4'h4,
    OP_SUB = 4'h5,
    OP_LOAD = 4'h6,
    OP_PRODUCT = 4'h7
  } op_type;

  typedef struct packed {
    logic [17:0] unused;
    logic signed [4:0] shift;
    logic carry;
    logic byte_mode;
    logic b_signed;
    logic a_signed;
    logic acc_second;
    logic [3:0] op;
  } cmd_type;

endpackage : mac_pkg

// ### tb/core_trap_sink.sv
// Core-side model that takes arithmetic warning traps
`timescale 1ns/1ps
`default_nettype none
module core_trap_sink (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Trap line and count
  input wire logic trap_i,
  output logic [7:0] taken_o
);
  logic seen_r;
  // Level trap: the core takes it once on each rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_r <= 1'b0;
      taken_o <= 8'h00;
    end else begin
      seen_r <= trap_i;
      if (trap_i && !seen_r) begin
        taken_o <= taken_o + 8'h01;
      end
    end
  end
endmodule : core_trap_sink
`default_nettype wire

// ### tb/mac_sva.sv
// Assertion checker for the multiply-accumulate register port
`timescale 1ns/1ps
`default_nettype none
module mac_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and core side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mac_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [mac_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [mac_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic arith_trap_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic mapped;
  assign mapped = wb_adr_i <= mac_pkg::OFS_TRAP_EN && wb_adr_i[1:0] == 2'b00;
  // ----------------------------------------------------------------
  // Request steps
  // ----------------------------------------------------------------
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_read(logic [7:0] a);
    s_take ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  a_ack_follows: assert property (s_take |=> wb_ack_o)
    else $error("request not answered");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |->
    $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_rdata_hold: assert property (
    !(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved");
  a_unmapped_zero: assert property (s_take ##0 (!wb_we_i && !mapped)
    |=> wb_dat_o == '0) else $error("unmapped read not zero");
  a_ovf_either: assert property (s_read(mac_pkg::OFS_STATUS) |=>
    wb_dat_o[11] == (wb_dat_o[15] | wb_dat_o[14])) else $error("bad ovf OR");
  a_clip_either: assert property (s_read(mac_pkg::OFS_STATUS) |=>
    wb_dat_o[10] == (wb_dat_o[13] | wb_dat_o[12])) else $error("bad clip OR");
  a_status_width: assert property (s_read(mac_pkg::OFS_STATUS) |=>
    wb_dat_o[31:16] == 16'h0000) else $error("status wider than 16");
  a_ctrl_bits: assert property (s_read(mac_pkg::OFS_CTRL) |=>
    (wb_dat_o & ~32'h000000D1) == '0) else $error("control spare bits set");
  a_trap_cause: assert property ($rose(arith_trap_o) |->
    $past(wb_ack_o && wb_we_i)) else $error("trap without write");
endmodule : mac_sva
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the multiply-accumulate unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic trap;
  logic [7:0] traps;
  logic [39:0] acc;
  logic [39:0] pexp [5] = '{40'h1FFFE, 40'hFFFFFFFE, 40'h1FFFE,
                            40'hFFFFFFFE, 40'hFFFE};
  int fail_count = 0;
  int checks = 0;
  always #20 clk_i = ~clk_i;
  dsp_multiply_accumulate dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .arith_trap_o(trap));
  core_trap_sink core (.clk_i(clk_i), .rst_i(rst_i), .trap_i(trap),
    .taken_o(traps));
  // ----------------------------------------------------------------
  // Bus access and comparison
  // ----------------------------------------------------------------
  task conclude;
    $display("mismatches %0d, comparisons %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until ack is seen at a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) fail_count++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task rchk(input logic [7:0] a, input logic [39:0] exp);
    bus(1'b0, a, 32'h0);
    chk({8'h00, rd}, exp);
  endtask : rchk
  // Accumulator is HI[7:0] joined to LO[31:0]
  task achk(input logic [7:0] lo, input logic [39:0] exp);
    bus(1'b0, lo, 32'h0);
    acc[31:0] = rd;
    bus(1'b0, lo + 8'h04, 32'h0);
    acc[39:32] = rd[7:0];
    chk(acc, exp);
  endtask : achk
  task op(input logic [3:0] o, input logic sec, input logic [1:0] sg,
          input logic byt, input logic cy, input logic [4:0] sh);
    mac_pkg::cmd_type c;
    c = {18'h0, sh, cy, byt, sg[1], sg[0], sec, o};
    bus(1'b1, mac_pkg::OFS_CMD, c);
  endtask : op
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(mac_pkg::OFS_STATUS, 40'h0);
    achk(mac_pkg::OFS_ACC1_LO, 40'h0);
    bus(1'b1, 8'hFC, 32'hFFFFFFFF);
    rchk(8'hFC, 40'h0);
    bus(1'b1, mac_pkg::OFS_CTRL, 32'h0000FFFF);
    rchk(mac_pkg::OFS_CTRL, 40'hD1);
    bus(1'b1, mac_pkg::OFS_OPER_A, 32'hFFFF);
    bus(1'b1, mac_pkg::OFS_OPER_B, 32'h0002);
    for (int i = 0; i < 5; i++) begin
      op(4'h7, 1'b0, i[1:0] | {2{i[2]}}, i[2], 1'b0, 5'h00);
      rchk(mac_pkg::OFS_PROD, pexp[i]);
    end
    bus(1'b1, mac_pkg::OFS_CTRL, 32'h01);
    bus(1'b1, mac_pkg::OFS_OPER_A, 32'h4000);
    bus(1'b1, mac_pkg::OFS_OPER_B, 32'h4000);
    op(4'h3, 1'b0, 2'b11, 1'b0, 1'b0, 5'h00);
    achk(mac_pkg::OFS_ACC1_LO, 40'h0020000000);
    bus(1'b1, mac_pkg::OFS_CTRL, 32'h81);
    bus(1'b1, mac_pkg::OFS_OPER_A, 32'h8000);
    bus(1'b1, mac_pkg::OFS_OPER_B, 32'h8000);
    op(4'h3, 1'b0, 2'b11, 1'b0, 1'b0, 5'h00);
    achk(mac_pkg::OFS_ACC1_LO, 40'h007FFFFFFF);
    rchk(mac_pkg::OFS_STATUS, 40'h2400);
    bus(1'b1, mac_pkg::OFS_OPER_A, 32'h4000);
    bus(1'b1, mac_pkg::OFS_OPER_B, 32'h4000);
    op(4'h2, 1'b0, 2'b11, 1'b0, 1'b0, 5'h00);
    achk(mac_pkg::OFS_ACC1_LO, 40'h005FFFFFFF);
    op(4'h1, 1'b0, 2'b11, 1'b0, 1'b0, 5'h00);
    achk(mac_pkg::OFS_ACC1_LO, 40'h007FFFFFFF);
    bus(1'b1, mac_pkg::OFS_CTRL, 32'h00);
    bus(1'b1, mac_pkg::OFS_TRAP_EN, 32'h02);
    bus(1'b1, mac_pkg::OFS_OPER_A, 32'h7FFF);
    op(4'h6, 1'b1, 2'b01, 1'b0, 1'b0, 5'h1F);
    op(4'h4, 1'b1, 2'b01, 1'b0, 1'b1, 5'h1E);
    achk(mac_pkg::OFS_ACC2_LO, 40'h02FFFA0001);
    rchk(mac_pkg::OFS_STATUS, 40'h6C00);
    chk({39'h0, trap}, 40'h1);
    chk({32'h0, traps}, 40'h1);
    op(4'h5, 1'b1, 2'b01, 1'b0, 1'b0, 5'h1E);
    achk(mac_pkg::OFS_ACC2_LO, 40'h00FFFE0001);
    rchk(mac_pkg::OFS_STATUS, 40'h2400);
    chk({39'h0, trap}, 40'h0);
    bus(1'b1, mac_pkg::OFS_CTRL, 32'h50);
    op(4'h6, 1'b1, 2'b01, 1'b0, 1'b0, 5'h18);
    op(4'h4, 1'b1, 2'b01, 1'b0, 1'b0, 5'h18);
    achk(mac_pkg::OFS_ACC2_LO, 40'h7FFFFFFFFF);
    rchk(mac_pkg::OFS_STATUS, 40'h3400);
    // Low lane only: status keeps its flags, command must not execute
    sel <= 4'h1;
    bus(1'b1, mac_pkg::OFS_STATUS, 32'h0000FFA5);
    op(4'h3, 1'b0, 2'b11, 1'b0, 1'b0, 5'h00);
    sel <= 4'hF;
    rchk(mac_pkg::OFS_STATUS, 40'h34A5);
    achk(mac_pkg::OFS_ACC1_LO, 40'h007FFFFFFF);
    bus(1'b1, mac_pkg::OFS_STATUS, 32'hA5);
    rchk(mac_pkg::OFS_STATUS, 40'hA5);
    conclude();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #160000;
    fail_count++;
    conclude();
  end
endmodule : testbench
bind dsp_multiply_accumulate mac_sva chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .arith_trap_o(arith_trap_o));
`default_nettype wire
